/* logic/lps_defines.vh */
`ifndef LPS_DEFINES_VH
`define LPS_DEFINES_VH

// ============================================================
// register byte addresses
`define LPS_ADDR_STATUS 12'h000
`define LPS_ADDR_CONTROL 12'h004
`define LPS_ADDR_CHANGE 12'h008
`define LPS_ADDR_RAW 12'h00C
`define LPS_ADDR_W 12

// ============================================================
// link status word bit positions
`define LPS_BIT_LINK 0
`define LPS_BIT_AN_FLAG 5
`define LPS_BIT_AN_DONE 6
`define LPS_BIT_PAR_DET 7
`define LPS_BIT_RSVD 8
`define LPS_BIT_GIG_FULL 9
`define LPS_BIT_GIG_HALF 10
`define LPS_BIT_FAST_T4 11
`define LPS_BIT_FAST_FULL 12
`define LPS_BIT_FAST_HALF 13
`define LPS_BIT_TEN_FULL 14
`define LPS_ABIL_LSB 9
`define LPS_ABIL_MSB 14
`define LPS_STATUS_MASK 32'h00007FE1

// ============================================================
// raw input vector layout (synchronised pins)
`define LPS_RAW_W 13
`define LPS_RAW_LINK 0
`define LPS_RAW_AN_SUP 1
`define LPS_RAW_AN_EN 2
`define LPS_RAW_AN_DONE 3
`define LPS_RAW_PAR_DET 4
`define LPS_RAW_ETH 5
`define LPS_RAW_SERDES 6
`define LPS_RAW_ABIL_LSB 7
`define LPS_RAW_ABIL_MSB 12
`define LPS_RAW_FLAGS_MSB 6
`define LPS_RAW_ABIL_SHIFT 8

// ============================================================
// control register fields and reset value
`define LPS_CTL_UPDATE 0
`define LPS_CTL_ZERO_ABIL 1
`define LPS_CTL_W 2
`define LPS_CTL_RESET 2'h3

// ============================================================
// change register fields
`define LPS_CHG_STICKY 0
`define LPS_CHG_CNT_LSB 8
`define LPS_CHG_CNT_MSB 15
`define LPS_CNT_W 8
`define LPS_CNT_MAX 8'hFF
`define LPS_CNT_ONE 8'h01

`define LPS_DATA_W 32
`define LPS_ZERO32 32'h00000000

`endif

/* logic/lps_sync.v */
// ============================================================
// two-stage synchroniser for a bundle of level inputs
module lps_sync #(
  parameter WIDTH = 13
) (
  input wire clock,
  input wire reset_n,
  input wire [WIDTH-1:0] async_in,
  output reg [WIDTH-1:0] sync_out
);

  // first stage is read only by the second stage
  reg [WIDTH-1:0] meta;

  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      meta <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule // lps_sync

/* logic/lps_word.v */
`include "lps_defines.vh"

// ============================================================
// maps synchronised link flags onto the status word
module lps_word (
  input wire [`LPS_RAW_W-1:0] raw,
  input wire zero_abil,
  output reg [`LPS_DATA_W-1:0] word
);

  reg an_flag;
  reg an_done;
  reg abil_valid;

  always @*
  begin
    word = `LPS_ZERO32;
    word[`LPS_BIT_LINK] = raw[`LPS_RAW_LINK];
    an_flag = raw[`LPS_RAW_AN_SUP] & raw[`LPS_RAW_AN_EN] & raw[`LPS_RAW_ETH];
    word[`LPS_BIT_AN_FLAG] = an_flag;
    // completion also counts a link won by parallel detection
    an_done = raw[`LPS_RAW_AN_DONE] | (raw[`LPS_RAW_PAR_DET] & raw[`LPS_RAW_ETH]);
    word[`LPS_BIT_AN_DONE] = an_done;
    word[`LPS_BIT_PAR_DET] = raw[`LPS_RAW_PAR_DET] & raw[`LPS_RAW_ETH];
    word[`LPS_BIT_RSVD] = 1'b0;
    abil_valid = raw[`LPS_RAW_ETH] & ~raw[`LPS_RAW_SERDES] & an_flag & an_done;
    if (abil_valid || !zero_abil)
    begin
      word[`LPS_ABIL_MSB:`LPS_ABIL_LSB] = raw[`LPS_RAW_ABIL_MSB:`LPS_RAW_ABIL_LSB];
    end
  end

endmodule // lps_word

/* logic/lps_status.v */
`include "lps_defines.vh"

module lps_status (
  input wire clock,
  input wire reset_n,
  input wire link_up,
  input wire an_supported,
  input wire an_enabled,
  input wire an_complete,
  input wire parallel_detect,
  input wire ethernet_link,
  input wire serdes_flag,
  input wire partner_gig_full,
  input wire partner_gig_half,
  input wire partner_fast_four_pair,
  input wire partner_fast_full,
  input wire partner_fast_half,
  input wire partner_ten_full,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`LPS_ADDR_W-1:0] paddr,
  input wire [`LPS_DATA_W-1:0] pwdata,
  input wire [3:0] pstrb,
  output reg [`LPS_DATA_W-1:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [`LPS_DATA_W-1:0] status_word
);

  // ============================================================
  // pin synchronisation
  wire [`LPS_RAW_W-1:0] pin_bundle;
  wire [`LPS_RAW_W-1:0] raw;

  assign pin_bundle = {
    partner_ten_full,
    partner_fast_half,
    partner_fast_full,
    partner_fast_four_pair,
    partner_gig_half,
    partner_gig_full,
    serdes_flag,
    ethernet_link,
    parallel_detect,
    an_complete,
    an_enabled,
    an_supported,
    link_up
  };

  lps_sync #(
    .WIDTH(`LPS_RAW_W)
  ) u_sync (
    .clock(clock),
    .reset_n(reset_n),
    .async_in(pin_bundle),
    .sync_out(raw)
  );

  // ============================================================
  // control register
  reg [`LPS_CTL_W-1:0] control;
  wire update_en;
  wire zero_abil;

  assign update_en = control[`LPS_CTL_UPDATE];
  assign zero_abil = control[`LPS_CTL_ZERO_ABIL];

  // ============================================================
  // status word assembly
  wire [`LPS_DATA_W-1:0] live_word;

  lps_word u_word (
    .raw(raw),
    .zero_abil(zero_abil),
    .word(live_word)
  );

  // ============================================================
  // apb decode
  wire setup_phase;
  wire access_done;
  wire wr_done;
  wire hit_status;
  wire hit_control;
  wire hit_change;
  wire hit_raw;
  wire hit_any;
  wire ctl_write;
  wire chg_write;

  assign setup_phase = psel & ~penable;
  assign access_done = psel & penable & pready;
  assign wr_done = access_done & pwrite & ~pslverr;

  function addr_is;
    input [`LPS_ADDR_W-1:0] addr;
    input [`LPS_ADDR_W-1:0] target;
    begin
      addr_is = (addr == target);
    end
  endfunction

  assign hit_status = addr_is(paddr, `LPS_ADDR_STATUS);
  assign hit_control = addr_is(paddr, `LPS_ADDR_CONTROL);
  assign hit_change = addr_is(paddr, `LPS_ADDR_CHANGE);
  assign hit_raw = addr_is(paddr, `LPS_ADDR_RAW);
  assign hit_any = hit_status | hit_control | hit_change | hit_raw;

  // byte lane 0 carries every writable field
  assign ctl_write = wr_done & hit_control & pstrb[0];
  assign chg_write = wr_done & hit_change & pstrb[0];

  // ============================================================
  // snapshot and change tracking
  reg change_sticky;
  reg [`LPS_CNT_W-1:0] change_count;
  reg [`LPS_CNT_W-1:0] next_change_count;
  reg next_change_sticky;
  wire word_differs;
  wire take_update;

  // while updating is off the word freezes, so software can read a
  // consistent picture; changes seen meanwhile are not counted
  assign take_update = update_en;
  assign word_differs = take_update & (live_word != status_word);

  always @*
  begin
    next_change_sticky = change_sticky;
    if (chg_write && pwdata[`LPS_CHG_STICKY])
    begin
      next_change_sticky = 1'b0;
    end
    // a change in the clearing cycle wins over the clear
    if (word_differs)
    begin
      next_change_sticky = 1'b1;
    end
  end

  always @*
  begin
    next_change_count = change_count;
    if (chg_write && pwdata[`LPS_CHG_STICKY])
    begin
      next_change_count = {`LPS_CNT_W{1'b0}};
    end
    if (word_differs)
    begin
      if (change_count != `LPS_CNT_MAX)
      begin
        next_change_count = change_count + `LPS_CNT_ONE;
      end
      else
      begin
        next_change_count = change_count;
      end
    end
  end

  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      status_word <= `LPS_ZERO32;
      change_sticky <= 1'b0;
      change_count <= {`LPS_CNT_W{1'b0}};
    end
    else
    begin
      if (take_update)
      begin
        status_word <= live_word & `LPS_STATUS_MASK;
      end
      change_sticky <= next_change_sticky;
      change_count <= next_change_count;
    end
  end

  // ============================================================
  // control register write
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      control <= `LPS_CTL_RESET;
    end
    else if (ctl_write)
    begin
      control <= pwdata[`LPS_CTL_W-1:0];
    end
  end

  // ============================================================
  // read data mux
  reg [`LPS_DATA_W-1:0] next_rdata;
  reg next_err;

  always @*
  begin
    next_rdata = `LPS_ZERO32;
    next_err = 1'b0;
    if (hit_status)
    begin
      next_rdata = status_word;
    end
    else if (hit_control)
    begin
      next_rdata[`LPS_CTL_W-1:0] = control;
    end
    else if (hit_change)
    begin
      next_rdata[`LPS_CHG_STICKY] = change_sticky;
      next_rdata[`LPS_CHG_CNT_MSB:`LPS_CHG_CNT_LSB] = change_count;
    end
    else if (hit_raw)
    begin
      next_rdata[`LPS_RAW_FLAGS_MSB:0] = raw[`LPS_RAW_FLAGS_MSB:0];
      next_rdata[`LPS_RAW_ABIL_SHIFT+5:`LPS_RAW_ABIL_SHIFT] =
        raw[`LPS_RAW_ABIL_MSB:`LPS_RAW_ABIL_LSB];
    end
    else
    begin
      next_err = 1'b1;
    end
    if (!hit_any)
    begin
      next_rdata = `LPS_ZERO32;
    end
  end

  // ============================================================
  // apb response: pready rises at setup, so no wait state; every output registered
  always @(posedge clock)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `LPS_ZERO32;
    end
    else if (setup_phase)
    begin
      pready <= 1'b1;
      pslverr <= next_err;
      // read data is sampled at setup; a change that lands in the
      // access cycle shows on the next read
      if (pwrite)
      begin
        prdata <= `LPS_ZERO32;
      end
      else
      begin
        prdata <= next_rdata;
      end
    end
    else if (access_done)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= `LPS_ZERO32;
    end
  end

endmodule // lps_status

/* test/lps_status_sva.sv */
// ============================================================
// status word follows the pins three edges later
module lps_status_sva (
  input wire clock,
  input wire reset_n,
  input wire link_up,
  input wire an_supported,
  input wire an_enabled,
  input wire an_complete,
  input wire parallel_detect,
  input wire ethernet_link,
  input wire serdes_flag,
  input wire partner_gig_full,
  input wire partner_gig_half,
  input wire partner_fast_four_pair,
  input wire partner_fast_full,
  input wire partner_fast_half,
  input wire partner_ten_full,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  input wire pready,
  input wire pslverr,
  input wire [31:0] status_word
);
  timeunit 1ns;
  timeprecision 100ps;
  wire eth_an = an_supported & an_enabled & ethernet_link;
  wire pd_eth = parallel_detect & ethernet_link;
  wire valid = eth_an & ~serdes_flag & (an_complete | pd_eth);
  wire [5:0] abil = {partner_ten_full, partner_fast_half, partner_fast_full,
    partner_fast_four_pair, partner_gig_half, partner_gig_full};
  wire [5:0] abil_q = valid ? abil : 6'h00;
  wire done_in = an_complete | pd_eth;
  // shadow of the control register, rebuilt from completed bus writes
  reg [1:0] ctl;
  always @(posedge clock)
  begin
    if (!reset_n)
      ctl <= 2'h3;
    else if (psel && penable && pready && pwrite && !pslverr && paddr == 12'h004 && pstrb[0])
      ctl <= pwdata[1:0];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_link_bit: assert property ($past(ctl[0]) |-> status_word[0] == $past(link_up, 3))
    else $error("link bit wrong");
  a_an_flag: assert property ($past(ctl[0]) |-> status_word[5] == $past(eth_an, 3))
    else $error("negotiation flag wrong");
  a_done_bit: assert property ($past(ctl[0]) |-> status_word[6] == $past(done_in, 3))
    else $error("done bit wrong");
  a_par_bit: assert property ($past(ctl[0]) |-> status_word[7] == $past(pd_eth, 3))
    else $error("parallel bit wrong");
  a_rsvd_bit: assert property (!status_word[8])
    else $error("reserved bit set");
  a_gig_bits: assert property ($past(ctl[0]) |-> status_word[10:9] ==
    ($past(ctl[1]) ? $past(abil_q[1:0], 3) : $past(abil[1:0], 3)))
    else $error("gigabit bits wrong");
  a_fast_bits: assert property ($past(ctl[0]) |-> status_word[13:11] ==
    ($past(ctl[1]) ? $past(abil_q[4:2], 3) : $past(abil[4:2], 3)))
    else $error("fast bits wrong");
  a_ten_bit: assert property ($rose(abil_q[5]) ##2 ctl[0] |-> ##1 status_word[14])
    else $error("ten bit late");
  a_word_frozen: assert property (!$past(ctl[0]) |-> $stable(status_word))
    else $error("frozen word moved");
  cover property (status_word[7]);
  cover property (status_word[14]);
  cover property (serdes_flag && status_word[6]);
  cover property (!ctl[0] && link_up && !status_word[0]);
endmodule // lps_status_sva

bind lps_status lps_status_sva u_sva (
  .clock(clock),
  .reset_n(reset_n),
  .link_up(link_up),
  .an_supported(an_supported),
  .an_enabled(an_enabled),
  .an_complete(an_complete),
  .parallel_detect(parallel_detect),
  .ethernet_link(ethernet_link),
  .serdes_flag(serdes_flag),
  .partner_gig_full(partner_gig_full),
  .partner_gig_half(partner_gig_half),
  .partner_fast_four_pair(partner_fast_four_pair),
  .partner_fast_full(partner_fast_full),
  .partner_fast_half(partner_fast_half),
  .partner_ten_full(partner_ten_full),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .pready(pready),
  .pslverr(pslverr),
  .status_word(status_word)
);

/* test/lps_link_partner.sv */
// ============================================================
// far end: drives abilities whatever the flags say
module lps_link_partner (
  input wire [12:0] cfg,
  output wire [12:0] pins
);
  timeunit 1ns;
  timeprecision 100ps;
  assign pins = cfg;
endmodule // lps_link_partner

/* test/link_partner_status_bits_test.sv */
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
module link_partner_status_bits_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, status_word;
  logic [12:0] cfg, pins;
  logic [3:0] pstrb;
  int n_mismatch = 0;
  int num_checks = 0;
  lps_link_partner peer (.cfg(cfg), .pins(pins));
  lps_status uut (.clock(clock), .reset_n(reset_n), .link_up(pins[0]),
    .an_supported(pins[1]), .an_enabled(pins[2]), .an_complete(pins[3]),
    .parallel_detect(pins[4]), .ethernet_link(pins[5]), .serdes_flag(pins[6]),
    .partner_gig_full(pins[7]), .partner_gig_half(pins[8]),
    .partner_fast_four_pair(pins[9]), .partner_fast_full(pins[10]),
    .partner_fast_half(pins[11]), .partner_ten_full(pins[12]), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .status_word(status_word));
  // ============================================================
  // bus and pin helpers
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] exp, input logic err);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      // only the watchdog ends a wait for the answer
      do
      begin
        @(posedge clock);
      end
      while (pready !== 1'b1);
      `CHK(pslverr, err)
      if (!w) `CHK(prdata, exp)
      psel <= 1'b0;
      penable <= 1'b0;
      // one idle edge so the next setup never lands in the release step
      @(posedge clock);
    end
  endtask
  task automatic apply(input logic [12:0] c, input logic [31:0] exp);
    begin
      cfg <= c;
      repeat (4) @(posedge clock);
      `CHK(status_word, exp)
      apb(1'b0, 12'h000, 32'h0, exp, 1'b0);
      apb(1'b0, 12'h00C, 32'h0, {18'h0, c[12:7], 1'b0, c[6:0]}, 1'b0);
    end
  endtask
  // ============================================================
  // scenarios
  task t_reset;
    begin
      apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
      apb(1'b0, 12'h010, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 12'h000, 32'hFFFFFFFF, 32'h0, 1'b0);
      apb(1'b0, 12'h000, 32'h0, 32'h0, 1'b0);
      $display("test reset done");
    end
  endtask
  task t_abil;
    begin
      for (int i = 0; i < 6; i++)
        apply(13'h002F | (13'h0080 << i), 32'h61 | (32'h200 << i));
      $display("test abilities done");
    end
  endtask
  task t_mask;
    begin
      apply(13'h1FEF, 32'h61);
      apply(13'h1F97, 32'h1);
      apply(13'h00B1, 32'hC1);
      apply(13'h0000, 32'h0);
      $display("test masking done");
    end
  endtask
  task t_ctl;
    begin
      apb(1'b1, 12'h004, 32'h0, 32'h0, 1'b0);
      apb(1'b0, 12'h004, 32'h0, 32'h0, 1'b0);
      apb(1'b1, 12'h008, 32'h1, 32'h0, 1'b0);
      apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b0);
      apply(13'h0001, 32'h0);
      apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b0);
      apb(1'b1, 12'h004, 32'h1, 32'h0, 1'b0);
      apb(1'b0, 12'h008, 32'h0, 32'h101, 1'b0);
      apply(13'h1FEF, 32'h7E61);
      apb(1'b1, 12'h004, 32'h3, 32'h0, 1'b0);
      apb(1'b0, 12'h000, 32'h0, 32'h61, 1'b0);
      apb(1'b0, 12'h008, 32'h0, 32'h301, 1'b0);
      apb(1'b1, 12'h008, 32'h1, 32'h0, 1'b0);
      apb(1'b0, 12'h008, 32'h0, 32'h0, 1'b0);
      // a write with lane 0 disabled must leave the control register alone
      pstrb <= 4'h0;
      apb(1'b1, 12'h004, 32'h0, 32'h0, 1'b0);
      pstrb <= 4'hF;
      apb(1'b0, 12'h004, 32'h0, 32'h3, 1'b0);
      apb(1'b1, 12'h010, 32'h0, 32'h0, 1'b1);
      $display("test control done");
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // ============================================================
  // clock, sequence and watchdog
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    repeat (3000) @(posedge clock);
    n_mismatch++;
    close_out;
  end
  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cfg = 13'h0000;
    pstrb = 4'hF;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    t_reset;
    t_abil;
    t_mask;
    t_ctl;
    close_out;
  end
endmodule // link_partner_status_bits_test
